// *** rtl/status_display_pkg.sv ***
// shared constants and types of the receiver status display registers
package status_display_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] ADDR_STRENGTH = 8'h20;
  localparam logic [7:0] ADDR_REG_TIMER = 8'h2b;
  localparam logic [7:0] ADDR_GAIN = 8'h2d;

  // ==========================================================================
  // field positions
  localparam int REG_CODE_LSB = 4;
  localparam int GPT_BIT = 2;
  localparam int NRT_BIT = 1;
  localparam int MRT_BIT = 0;
  localparam int AM_NIBBLE_LSB = 4;
  localparam int PM_NIBBLE_LSB = 0;

  // ==========================================================================
  // code limits and reset values
  localparam int CODE_W = 4;
  localparam logic [3:0] REG_CODE_MAX = 4'hf;
  localparam logic [3:0] REG_CODE_MIN = 4'h5;
  localparam logic [3:0] STRENGTH_MAX = 4'hd;
  localparam logic [3:0] GAIN_MAX = 4'hf;
  localparam logic [7:0] STRENGTH_RESET = 8'h00;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // channel index in per-channel arrays
  localparam int CH_PM = 0;
  localparam int CH_AM = 1;
  localparam int NUM_CH = 2;

  // ==========================================================================
  // types
  typedef enum logic {
    SRC_ADJUST,
    SRC_EXTERNAL
  } reg_src_t;

  typedef struct packed {
    logic [3:0] am;
    logic [3:0] pm;
  } chan_pair_t;

  typedef struct packed {
    logic gpt_on;
    logic nrt_on;
    logic mrt_on;
  } timer_flags_t;

  typedef struct packed {
    logic [3:0] reg_cut;
    logic [3:0] squelch_cut;
    logic [3:0] agc_cut;
  } gain_parts_t;

endpackage : status_display_pkg

// *** rtl/strength_peak_hold.sv ***
// peak detector for one receive channel signal strength code
`timescale 1ns/10ps
`default_nettype none

module strength_peak_hold
  import status_display_pkg::*;
#(
  parameter int W = CODE_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic level_valid,
  input wire logic [W-1:0] level,
  output logic [W-1:0] peak
);

  // ==========================================================================
  // limit and compare
  logic [W-1:0] peak_q;
  logic [W-1:0] peak_d;
  wire logic [W-1:0] level_cap = (level > W'(STRENGTH_MAX)) ? W'(STRENGTH_MAX) : level;
  wire logic take = level_valid && (level_cap > peak_q);

  // a sample in the clearing cycle starts the new peak instead of being lost
  assign peak_d = clear ? (level_valid ? level_cap : '0) : (take ? level_cap : peak_q);

  // peak register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      peak_q <= '0;
    end else begin
      peak_q <= peak_d;
    end
  end

  assign peak = peak_q;

endmodule : strength_peak_hold
`default_nettype wire

// *** rtl/gain_cut_combine.sv ***
// saturating sum of the three second-stage gain reduction contributions
`timescale 1ns/10ps
`default_nettype none

module gain_cut_combine
  import status_display_pkg::*;
(
  input wire gain_parts_t parts,
  output logic [3:0] total
);

  // ==========================================================================
  // sum with two spare bits, then clip at the top code
  wire logic [5:0] sum = {2'b00, parts.reg_cut} + {2'b00, parts.squelch_cut} + {2'b00, parts.agc_cut};

  assign total = (sum > {2'b00, GAIN_MAX}) ? GAIN_MAX : sum[3:0];

endmodule : gain_cut_combine
`default_nettype wire

// *** rtl/receiver_status_display_regs.sv ***
// read-only status display registers of the receiver front end
`timescale 1ns/10ps
`default_nettype none

module receiver_status_display_regs
  import status_display_pkg::*;
#(
  parameter int CODE_BITS = CODE_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // commands
  input wire logic set_default,
  input wire logic clear_strength_cmd,
  input wire logic message_start,
  // regulator setting
  input wire logic adjust_done,
  input wire logic [3:0] adjust_code,
  input wire logic reg_mode_ext,
  input wire logic [3:0] ext_reg_code,
  output logic [3:0] applied_reg_code,
  // timers
  input wire timer_flags_t timers_running,
  // receive channel strength samples
  input wire logic am_level_valid,
  input wire logic [3:0] am_level,
  input wire logic pm_level_valid,
  input wire logic [3:0] pm_level,
  input wire logic strength_sel_pm,
  output logic [3:0] selected_strength,
  // gain reduction contributions
  input wire gain_parts_t am_gain_parts,
  input wire gain_parts_t pm_gain_parts
);

  // ==========================================================================
  // elaboration check
  if (CODE_BITS != CODE_W) begin : g_bad_width
    $error("code width must be four bits");
  end

  // ==========================================================================
  // address decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_STRENGTH) || (a == ADDR_REG_TIMER) || (a == ADDR_GAIN);
  endfunction : is_mapped

  wire logic rd_strength = reg_rd && (reg_addr == ADDR_STRENGTH);
  wire logic rd_reg_timer = reg_rd && (reg_addr == ADDR_REG_TIMER);
  wire logic rd_gain = reg_rd && (reg_addr == ADDR_GAIN);
  wire logic rd_unmapped = reg_rd && !is_mapped(reg_addr);

  // writes reach no storage here; the port is accepted and dropped
  wire logic wr_dropped = reg_wr && (reg_wdata == reg_wdata);

  // ==========================================================================
  // regulated voltage code
  logic [3:0] adjust_code_q;
  logic [3:0] adjust_code_d;
  logic [3:0] reg_code_q;
  logic [3:0] reg_code_d;
  reg_src_t reg_src;

  // the adjust result is kept; set-default returns it to the top code
  assign adjust_code_d = set_default ? REG_CODE_MAX : (adjust_done ? adjust_code : adjust_code_q);

  // mode bit chooses which code is applied
  assign reg_src = reg_mode_ext ? SRC_EXTERNAL : SRC_ADJUST;
  wire logic [3:0] reg_code_raw = (reg_src == SRC_EXTERNAL) ? ext_reg_code : adjust_code_d;

  // codes below the lowest step are unused and held at the lowest step
  assign reg_code_d = (reg_code_raw < REG_CODE_MIN) ? REG_CODE_MIN : reg_code_raw;

  // regulator code registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      adjust_code_q <= REG_CODE_MAX;
      reg_code_q <= REG_CODE_MAX;
    end else begin
      adjust_code_q <= adjust_code_d;
      reg_code_q <= reg_code_d;
    end
  end

  assign applied_reg_code = reg_code_q;

  // ==========================================================================
  // timer running flags
  timer_flags_t timers_q;

  // flags follow the timers, one cycle behind
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timers_q <= '0;
    end else begin
      timers_q <= timers_running;
    end
  end

  // ==========================================================================
  // signal strength peaks
  wire logic strength_clear = message_start || clear_strength_cmd || set_default;
  wire logic [NUM_CH-1:0] level_valid_arr = {am_level_valid, pm_level_valid};
  wire logic [NUM_CH-1:0][3:0] level_arr = {am_level, pm_level};
  logic [NUM_CH-1:0][3:0] peak_arr;
  chan_pair_t strength;

  // one peak detector per channel
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_peak
    strength_peak_hold #(
      .W(CODE_BITS)
    ) u_peak (
      .mclk(mclk),
      .arst_n(arst_n),
      .clear(strength_clear),
      .level_valid(level_valid_arr[ch]),
      .level(level_arr[ch]),
      .peak(peak_arr[ch])
    );
  end

  assign strength.am = peak_arr[CH_AM];
  assign strength.pm = peak_arr[CH_PM];

  // channel choice for internal use
  logic [3:0] selected_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      selected_q <= '0;
    end else begin
      selected_q <= strength_sel_pm ? strength.pm : strength.am;
    end
  end

  assign selected_strength = selected_q;

  // ==========================================================================
  // gain reduction state
  logic [3:0] am_gain_total;
  logic [3:0] pm_gain_total;
  chan_pair_t gain_q;
  chan_pair_t gain_d;

  gain_cut_combine u_am_gain (
    .parts(am_gain_parts),
    .total(am_gain_total)
  );

  gain_cut_combine u_pm_gain (
    .parts(pm_gain_parts),
    .total(pm_gain_total)
  );

  // set-default shows zero for a cycle, then the live value returns
  assign gain_d = set_default ? chan_pair_t'(GAIN_RESET) : chan_pair_t'({am_gain_total, pm_gain_total});

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gain_q <= chan_pair_t'(GAIN_RESET);
    end else begin
      gain_q <= gain_d;
    end
  end

  // ==========================================================================
  // read data
  wire logic [7:0] reg_timer_word = {reg_code_q, 1'b0, timers_q.gpt_on, timers_q.nrt_on, timers_q.mrt_on};
  wire logic [7:0] read_mux = rd_strength ? strength :
                              rd_reg_timer ? reg_timer_word :
                              rd_gain ? gain_q :
                              READ_IDLE;
  logic [7:0] rdata_q;

  // data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= READ_IDLE;
    end else begin
      rdata_q <= read_mux;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================================
  // checks
  a_regcode_read: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_reg_timer |=> (reg_rdata[7:REG_CODE_LSB] == $past(reg_code_q)) && !reg_rdata[3])
    else $error("regulator code read back wrong");

  a_regcode_default: assert property (@(posedge mclk) disable iff (!arst_n)
    set_default && !reg_mode_ext |=> applied_reg_code == REG_CODE_MAX)
    else $error("set-default did not apply top code");

  a_regcode_range: assert property (@(posedge mclk) disable iff (!arst_n)
    applied_reg_code >= REG_CODE_MIN)
    else $error("applied code below lowest step");

  a_timer_flags: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_reg_timer ##1 $past(arst_n, 2) |-> (reg_rdata[GPT_BIT] == $past(timers_running.gpt_on, 2))
      && (reg_rdata[NRT_BIT] == $past(timers_running.nrt_on, 2))
      && (reg_rdata[MRT_BIT] == $past(timers_running.mrt_on, 2)))
    else $error("timer flags not shown");

  a_am_peak_read: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_strength |=> reg_rdata[7:AM_NIBBLE_LSB] == $past(peak_arr[CH_AM]))
    else $error("am peak read back wrong");

  a_pm_peak_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !strength_clear && pm_level_valid && (pm_level <= STRENGTH_MAX) && (pm_level > strength.pm)
      |=> strength.pm == $past(pm_level))
    else $error("pm peak not taken");

  a_peak_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (message_start || clear_strength_cmd) && !am_level_valid && !pm_level_valid |=> strength == STRENGTH_RESET)
    else $error("peaks not cleared");

  a_default_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    set_default && !am_level_valid && !pm_level_valid |=> strength == STRENGTH_RESET)
    else $error("strength not zero after set-default");

  a_strength_cap: assert property (@(posedge mclk) disable iff (!arst_n)
    (strength.am <= STRENGTH_MAX) && (strength.pm <= STRENGTH_MAX))
    else $error("unused strength code held");

  a_gain_read: assert property (@(posedge mclk) disable iff (!arst_n)
    !set_default ##1 rd_gain |=> reg_rdata[7:AM_NIBBLE_LSB] == $past(am_gain_total, 2))
    else $error("am gain reduction read wrong");

  a_gain_pm: assert property (@(posedge mclk) disable iff (!arst_n)
    !set_default |=> gain_q.pm == $past(pm_gain_total))
    else $error("pm gain reduction wrong");

  a_sel_channel: assert property (@(posedge mclk) disable iff (!arst_n)
    strength_sel_pm |=> selected_strength == $past(strength.pm))
    else $error("selected strength is not pm");

  a_ext_source: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_mode_ext && (ext_reg_code >= REG_CODE_MIN) |=> applied_reg_code == $past(ext_reg_code))
    else $error("external code not applied");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    (rd_unmapped || (wr_dropped && !reg_rd)) |=> reg_rdata == READ_IDLE)
    else $error("unmapped read or write gave data");

  a_gain_default: assert property (@(posedge mclk) disable iff (!arst_n)
    set_default |=> gain_q == GAIN_RESET)
    else $error("gain reduction not zero after set-default");

  a_gain_am: assert property (@(posedge mclk) disable iff (!arst_n)
    !set_default |=> gain_q.am == $past(am_gain_total))
    else $error("am gain reduction wrong");

  a_pm_peak_read: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_strength |=> reg_rdata[AM_NIBBLE_LSB-1:PM_NIBBLE_LSB] == $past(peak_arr[CH_PM]))
    else $error("pm peak read back wrong");

  a_am_peak_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !strength_clear && am_level_valid && (am_level <= STRENGTH_MAX) && (am_level > strength.am)
      |=> strength.am == $past(am_level))
    else $error("am peak not taken");

  a_peak_keep: assert property (@(posedge mclk) disable iff (!arst_n)
    !strength_clear |=> (strength.am >= $past(strength.am)) && (strength.pm >= $past(strength.pm)))
    else $error("peak dropped without clear");

  a_sel_am: assert property (@(posedge mclk) disable iff (!arst_n)
    !strength_sel_pm |=> selected_strength == $past(strength.am))
    else $error("selected strength is not am");

  a_adjust_source: assert property (@(posedge mclk) disable iff (!arst_n)
    !reg_mode_ext && !set_default && adjust_done && (adjust_code >= REG_CODE_MIN) |=> applied_reg_code == $past(adjust_code))
    else $error("adjust result not applied");

  a_adjust_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !set_default && !adjust_done |=> adjust_code_q == $past(adjust_code_q))
    else $error("stored adjust result changed");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == READ_IDLE)
    else $error("read data without read strobe");

endmodule : receiver_status_display_regs
`default_nettype wire

// *** sim/tb.sv ***
// self-checking testbench of the receiver status display registers
`timescale 1ns/10ps
`default_nettype none

module tb
  import status_display_pkg::*;
;
  // ==========================================================================
  // clock, reset and design inputs
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic set_default = 1'b0;
  logic clear_strength_cmd = 1'b0;
  logic message_start = 1'b0;
  logic adjust_done = 1'b0;
  logic [3:0] adjust_code = 4'h0;
  logic reg_mode_ext = 1'b0;
  logic [3:0] ext_reg_code = 4'h0;
  logic [3:0] applied_reg_code;
  timer_flags_t timers_running = '0;
  logic am_level_valid = 1'b0;
  logic [3:0] am_level = 4'h0;
  logic pm_level_valid = 1'b0;
  logic [3:0] pm_level = 4'h0;
  logic strength_sel_pm = 1'b0;
  logic [3:0] selected_strength;
  gain_parts_t am_gain_parts = '0;
  gain_parts_t pm_gain_parts = '0;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  receiver_status_display_regs u_receiver_status_display_regs (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .set_default(set_default),
    .clear_strength_cmd(clear_strength_cmd), .message_start(message_start), .adjust_done(adjust_done),
    .adjust_code(adjust_code), .reg_mode_ext(reg_mode_ext), .ext_reg_code(ext_reg_code),
    .applied_reg_code(applied_reg_code), .timers_running(timers_running),
    .am_level_valid(am_level_valid), .am_level(am_level), .pm_level_valid(pm_level_valid),
    .pm_level(pm_level), .strength_sel_pm(strength_sel_pm), .selected_strength(selected_strength),
    .am_gain_parts(am_gain_parts), .pm_gain_parts(pm_gain_parts)
  );

  // ==========================================================================
  // verdict and hang guard
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // cut the run short if it never reaches its end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end

  // ==========================================================================
  // access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // read strobe one cycle, data sampled mid-cycle after it
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // one cycle of strength samples on both channels, then idle
  task automatic feed(input logic [3:0] a, input logic [3:0] p);
    @(posedge mclk);
    am_level_valid <= 1'b1;
    pm_level_valid <= 1'b1;
    am_level <= a;
    pm_level <= p;
    @(posedge mclk);
    am_level_valid <= 1'b0;
    pm_level_valid <= 1'b0;
  endtask : feed

  // 0 message start, 1 clear strength, 2 set default
  task automatic cmd(input int k);
    @(posedge mclk);
    message_start <= (k == 0);
    clear_strength_cmd <= (k == 1);
    set_default <= (k == 2);
    @(posedge mclk);
    message_start <= 1'b0;
    clear_strength_cmd <= 1'b0;
    set_default <= 1'b0;
  endtask : cmd

  // ==========================================================================
  // main sequence
  initial begin
    cyc(12);
    arst_n <= 1'b1;
    cyc(2);
    rd_chk(8'h2b, 8'hf0);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h2d, 8'h00);
    rd_chk(8'h21, 8'h00);
    rd_chk(8'h2b, 8'hf0);
    @(negedge mclk);
    chk(reg_rdata, 8'h00);
    // each timer flag alone
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      timers_running <= timer_flags_t'(3'h1 << i);
      cyc(2);
      rd_chk(8'h2b, {4'hf, 1'b0, 3'h1 << i});
    end
    @(posedge mclk);
    timers_running <= '0;
    // adjust result, then every external code
    @(posedge mclk);
    adjust_code <= 4'h9;
    adjust_done <= 1'b1;
    @(posedge mclk);
    adjust_done <= 1'b0;
    cyc(2);
    rd_chk(8'h2b, 8'h90);
    chk({4'h0, applied_reg_code}, 8'h09);
    @(posedge mclk);
    reg_mode_ext <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      @(posedge mclk);
      ext_reg_code <= 4'(c);
      cyc(2);
      rd_chk(8'h2b, {(c < 5) ? 4'h5 : 4'(c), 4'h0});
    end
    @(posedge mclk);
    reg_mode_ext <= 1'b0;
    cyc(2);
    rd_chk(8'h2b, 8'h90);
    cmd(2);
    cyc(2);
    rd_chk(8'h2b, 8'hf0);
    // gain reduction sums
    @(posedge mclk);
    am_gain_parts <= {4'h1, 4'h2, 4'h3};
    pm_gain_parts <= {4'h8, 4'h8, 4'h8};
    cyc(2);
    rd_chk(8'h2d, 8'h6f);
    // peaks with clipped samples
    feed(4'h3, 4'h1);
    feed(4'h8, 4'he);
    feed(4'h5, 4'hf);
    cyc(2);
    rd_chk(8'h20, 8'h8d);
    @(negedge mclk);
    chk({4'h0, selected_strength}, 8'h08);
    @(posedge mclk);
    strength_sel_pm <= 1'b1;
    cyc(2);
    @(negedge mclk);
    chk({4'h0, selected_strength}, 8'h0d);
    // writes leave every register alone
    wr(8'h20, 8'h00);
    wr(8'h2b, 8'h0f);
    wr(8'h2d, 8'h00);
    rd_chk(8'h20, 8'h8d);
    rd_chk(8'h2b, 8'hf0);
    rd_chk(8'h2d, 8'h6f);
    // every clearing event empties both peaks
    for (int k = 0; k < 3; k++) begin
      cmd(0);
      feed(4'(k + 1), 4'(k + 2));
      cyc(2);
      rd_chk(8'h20, {4'(k + 1), 4'(k + 2)});
      cmd(k);
      cyc(2);
      rd_chk(8'h20, 8'h00);
    end
    rd_chk(8'h2d, 8'h6f);
    stop_test();
  end

endmodule : tb

`default_nettype wire
